// >>> aux_function_output_handshake.sv
// Output-side control of a machine-tool controller with auxiliary function handshake.
//
// Summary of operation
// - The emergency output rests low and rises on an emergency when polarity is 0, and the reverse when it is 1.
// - Pin thirteen carries decoded output thirteen, ORed with positive turret rotation when turret_dir_enable is set.
// - Pin fourteen carries decoded output fourteen, ORed with any rapid traverse move when rapid_ind_enable is set.
// - The cycle indicator shows a threading cycle at select 0, or any executing block or start command at select 1.
// - A decoded miscellaneous function sets and clears the decoded outputs given by its table entry.
// - A decoded function also goes out on the BCD lines at bcd_suppress 0 and only on decoded outputs at 1.
// - Without edge wait the code stands 200 ms, then the block waits for aux_done_ack high before completing.
// - With edge wait the matching strobe rises 50 ms after the code is placed on the lines.
// - With edge wait and the strobe up, the block waits while aux_done_ack is high.
// - With edge wait, once aux_done_ack is low the strobe stays 100 ms more and then drops.
// - With edge wait, the code stays on the lines 50 ms after the strobe drops.
// - With edge wait, after the code hold the block waits for aux_done_ack high before completing.
// - Each of five feedback connectors raises its alarm on bad feedback unless its cancel bit is 1.
`timescale 1ns/1ns

module aux_function_output_handshake
#(
  parameter int unsigned TICK_CYCLES = aux_out_pkg::TICK_CYCLES
)
(
  // Clock and reset.
  input  wire logic                                       core_clk,
  input  wire logic                                       reset,
  // Configuration.
  input  wire aux_out_pkg::io_config_t                    config_bits,
  input  wire logic [aux_out_pkg::FB_CONN-1:0]            feedback_alarm_cancel,
  // Decode table write port.
  input  wire logic                                       table_write,
  input  wire logic [6:0]                                 table_index,
  input  wire aux_out_pkg::decode_entry_t                 table_entry,
  // Request from the program executor.
  input  wire aux_out_pkg::aux_request_t                  request,
  output logic                                            request_ready,
  output logic                                            function_done,
  // Machine state pins.
  input  wire logic                                       emergency,
  input  wire logic                                       turret_positive,
  input  wire logic                                       rapid_traverse,
  input  wire logic                                       threading_active_indicator,
  input  wire logic                                       block_executing,
  input  wire logic                                       start_cmd_executing,
  input  wire logic [aux_out_pkg::FB_CONN-1:0]            feedback_fault,
  input  wire logic                                       aux_done_ack,
  // Cabinet outputs.
  output logic                                            emergency_out,
  output logic                                            cycle_indicator,
  output logic [aux_out_pkg::BCD_W-1:0]                   bcd_code_lines,
  output aux_out_pkg::strobe_t                            strobes,
  output logic [aux_out_pkg::DEC_W-1:0]                   decoded_pins,
  output logic [aux_out_pkg::FB_CONN-1:0]                 feedback_alarm
);

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  localparam int unsigned SYNC_W = 7 + aux_out_pkg::FB_CONN;

  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_pins;
  logic              ack;
  logic              emg_s;
  logic              turret_s;
  logic              rapid_s;
  logic              thread_s;
  logic              block_s;
  logic              start_s;
  logic [aux_out_pkg::FB_CONN-1:0] fb_fault_s;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      sync_meta <= '0;
      sync_pins <= '0;
    end
    else
    begin
      sync_meta <= {feedback_fault, aux_done_ack, emergency, turret_positive, rapid_traverse,
                    threading_active_indicator, block_executing, start_cmd_executing};
      sync_pins <= sync_meta;
    end
  end

  assign {fb_fault_s, ack, emg_s, turret_s, rapid_s, thread_s, block_s, start_s} = sync_pins;

  // ****************************************************************
  // Millisecond tick divider.
  // ****************************************************************
  logic [aux_out_pkg::TICK_CNT_W-1:0] tick_cnt;
  logic                               ms_tick;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      tick_cnt <= '0;
      ms_tick  <= 1'b0;
    end
    else if (tick_cnt == aux_out_pkg::TICK_CNT_W'(TICK_CYCLES - 1))
    begin
      tick_cnt <= '0;
      ms_tick  <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 1'b1;
      ms_tick  <= 1'b0;
    end
  end

  // ****************************************************************
  // Decode table storage.
  // ****************************************************************
  aux_out_pkg::decode_entry_t decode_table [aux_out_pkg::TABLE_DEPTH];

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < aux_out_pkg::TABLE_DEPTH; i++)
      begin
        decode_table[i] <= '0;
      end
    end
    else if (table_write && (table_index < 7'(aux_out_pkg::TABLE_DEPTH)))
    begin
      decode_table[table_index] <= table_entry;
    end
  end

  // ****************************************************************
  // Handshake sequencer.
  // ****************************************************************
  typedef enum logic [2:0]
  {
    IDLE       = 3'b000,
    CODE_ONLY  = 3'b001,
    PRE_STROBE = 3'b010,
    WAIT_LOW   = 3'b011,
    STB_HOLD   = 3'b100,
    CODE_HOLD  = 3'b101,
    WAIT_HIGH  = 3'b110
  } seq_state_t;

  seq_state_t                       state;
  logic [aux_out_pkg::MS_CNT_W-1:0] ms_cnt;
  aux_out_pkg::func_kind_t          kind;
  logic [aux_out_pkg::DEC_W-1:0]    dec_bits;
  logic                             drive_code;
  aux_out_pkg::decode_entry_t       hit;
  logic                             is_decoded;

  assign hit        = decode_table[request.code[6:0]];
  assign is_decoded = (request.kind == aux_out_pkg::FUNC_M)
                      && (request.code < 8'(aux_out_pkg::TABLE_DEPTH)) && hit.valid;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state          <= IDLE;
      ms_cnt         <= '0;
      kind           <= aux_out_pkg::FUNC_M;
      bcd_code_lines <= '0;
      drive_code     <= 1'b0;
      strobes        <= '0;
      request_ready  <= 1'b1;
      function_done  <= 1'b0;
      dec_bits       <= '0;
    end
    else
    begin
      function_done <= 1'b0;
      if (ms_tick)
      begin
        ms_cnt <= ms_cnt + 1'b1;
      end
      unique case (state)
        IDLE:
        begin
          if (request.valid)
          begin
            kind          <= request.kind;
            request_ready <= 1'b0;
            ms_cnt        <= '0;
            if (is_decoded)
            begin
              dec_bits <= (dec_bits & ~hit.clear_mask) | hit.set_mask;
            end
            if (is_decoded && config_bits.bcd_suppress)
            begin
              state         <= IDLE;
              request_ready <= 1'b1;
              function_done <= 1'b1;
            end
            else
            begin
              bcd_code_lines <= request.code;
              drive_code     <= 1'b1;
              state          <= config_bits.falling_edge_wait ? PRE_STROBE : CODE_ONLY;
            end
          end
        end
        CODE_ONLY:
        begin
          if (ms_cnt == aux_out_pkg::MS_CNT_W'(aux_out_pkg::CODE_ONLY_MS))
          begin
            bcd_code_lines <= '0;
            drive_code     <= 1'b0;
            state          <= WAIT_HIGH;
          end
        end
        PRE_STROBE:
        begin
          if (ms_cnt == aux_out_pkg::MS_CNT_W'(aux_out_pkg::CODE_TO_STB_MS))
          begin
            strobes.m <= (kind == aux_out_pkg::FUNC_M);
            strobes.s <= (kind == aux_out_pkg::FUNC_S);
            strobes.t <= (kind == aux_out_pkg::FUNC_T);
            state     <= WAIT_LOW;
          end
        end
        WAIT_LOW:
        begin
          ms_cnt <= '0;
          if (!ack)
          begin
            state <= STB_HOLD;
          end
        end
        STB_HOLD:
        begin
          if (ms_cnt == aux_out_pkg::MS_CNT_W'(aux_out_pkg::STB_HOLD_MS))
          begin
            strobes <= '0;
            ms_cnt  <= '0;
            state   <= CODE_HOLD;
          end
        end
        CODE_HOLD:
        begin
          if (ms_cnt == aux_out_pkg::MS_CNT_W'(aux_out_pkg::CODE_HOLD_MS))
          begin
            bcd_code_lines <= '0;
            drive_code     <= 1'b0;
            state          <= WAIT_HIGH;
          end
        end
        WAIT_HIGH:
        begin
          if (ack)
          begin
            state         <= IDLE;
            request_ready <= 1'b1;
            function_done <= 1'b1;
          end
        end
        default:
        begin
          state <= IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Indicator and shared pin outputs.
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      emergency_out   <= 1'b0;
      cycle_indicator <= 1'b0;
      decoded_pins    <= '0;
    end
    else
    begin
      emergency_out   <= emg_s ^ config_bits.emergency_polarity_sel;
      cycle_indicator <= config_bits.cycle_ind_select ? (block_s | start_s) : thread_s;
      decoded_pins    <= dec_bits;
      decoded_pins[aux_out_pkg::DEC_IDX_13] <= dec_bits[aux_out_pkg::DEC_IDX_13]
                                               | (config_bits.turret_dir_enable & turret_s);
      decoded_pins[aux_out_pkg::DEC_IDX_14] <= dec_bits[aux_out_pkg::DEC_IDX_14]
                                               | (config_bits.rapid_ind_enable & rapid_s);
    end
  end

  // ****************************************************************
  // Feedback alarms.
  // ****************************************************************
  generate
    for (genvar c = 0; c < aux_out_pkg::FB_CONN; c++)
    begin : g_fb
      always_ff @(posedge core_clk)
      begin
        if (reset)
        begin
          feedback_alarm[c] <= 1'b0;
        end
        else
        begin
          feedback_alarm[c] <= fb_fault_s[c] & ~feedback_alarm_cancel[c];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  emergency_level_a: assert property (@(posedge core_clk) disable iff (reset)
    ##1 emergency_out == ($past(emg_s) ^ $past(config_bits.emergency_polarity_sel)))
    else $error("Emergency output level wrong.");
  turret_pin_a: assert property (@(posedge core_clk) disable iff (reset)
    (config_bits.turret_dir_enable && turret_s) |=> decoded_pins[aux_out_pkg::DEC_IDX_13])
    else $error("Turret direction not shown.");
  rapid_pin_a: assert property (@(posedge core_clk) disable iff (reset)
    (config_bits.rapid_ind_enable && rapid_s) |=> decoded_pins[aux_out_pkg::DEC_IDX_14])
    else $error("Rapid traverse not shown.");
  cycle_thread_a: assert property (@(posedge core_clk) disable iff (reset)
    (!config_bits.cycle_ind_select && $stable(config_bits) && thread_s) |=> cycle_indicator)
    else $error("Threading not shown.");
  strobe_needs_code_a: assert property (@(posedge core_clk) disable iff (reset)
    (strobes != '0) |-> drive_code)
    else $error("Strobe without code.");
  strobe_wait_ack_a: assert property (@(posedge core_clk) disable iff (reset)
    (state == WAIT_LOW && ack) |=> (state == WAIT_LOW) && (strobes != '0))
    else $error("Strobe left before ack fell.");
  strobe_rise_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(state == WAIT_LOW) |-> $past(state) == PRE_STROBE)
    else $error("Strobe raised out of order.");
  code_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    $fell(strobes != '0) |-> drive_code && state == CODE_HOLD)
    else $error("Code dropped with strobe.");
  done_ack_a: assert property (@(posedge core_clk) disable iff (reset)
    (function_done && !$past(state == IDLE)) |-> $past(ack))
    else $error("Completed without ack high.");
  alarm_cancel_a: assert property (@(posedge core_clk) disable iff (reset)
    ##1 feedback_alarm == ($past(fb_fault_s) & ~$past(feedback_alarm_cancel)))
    else $error("Feedback alarm wrong.");

  code_only_c: cover property (@(posedge core_clk) disable iff (reset)
    state == CODE_ONLY ##1 state == WAIT_HIGH);
  strobe_c: cover property (@(posedge core_clk) disable iff (reset)
    state == STB_HOLD ##1 state == CODE_HOLD);
  suppressed_c: cover property (@(posedge core_clk) disable iff (reset)
    state == IDLE && request.valid && is_decoded && config_bits.bcd_suppress);

endmodule

// >>> aux_function_output_handshake_tb_top.sv
// Self-checking testbench of the auxiliary function output block.
`timescale 1ns/1ns

module aux_function_output_handshake_tb_top;
  localparam int T = 20;
  logic                        core_clk;
  logic                        reset;
  aux_out_pkg::io_config_t     cfg;
  logic [4:0]                  cancel;
  logic                        table_write;
  logic [6:0]                  table_index;
  aux_out_pkg::decode_entry_t  table_entry;
  aux_out_pkg::aux_request_t   request;
  logic                        request_ready;
  logic                        function_done;
  logic                        emergency;
  logic                        turret_positive;
  logic                        rapid_traverse;
  logic                        threading;
  logic                        block_exec;
  logic                        start_exec;
  logic [4:0]                  feedback_fault;
  logic                        ack;
  logic                        emergency_out;
  logic                        cycle_indicator;
  logic [7:0]                  bcd;
  aux_out_pkg::strobe_t        strobes;
  logic [15:0]                 decoded_pins;
  logic [4:0]                  feedback_alarm;
  logic                        edge_mode;
  logic [31:0]                 low_delay;
  logic [31:0]                 high_delay;
  int                          n_fail;
  int                          n_checks;
  int                          t_on, t_off, t_son, t_soff, t_al, t_ah, t_done;
  logic [7:0]                  bcd_seen;
  logic [2:0]                  stb_seen;

  aux_function_output_handshake #(.TICK_CYCLES(T)) dut
  (
    .core_clk(core_clk), .reset(reset), .config_bits(cfg), .feedback_alarm_cancel(cancel),
    .table_write(table_write), .table_index(table_index), .table_entry(table_entry),
    .request(request), .request_ready(request_ready), .function_done(function_done),
    .emergency(emergency), .turret_positive(turret_positive), .rapid_traverse(rapid_traverse),
    .threading_active_indicator(threading), .block_executing(block_exec),
    .start_cmd_executing(start_exec), .feedback_fault(feedback_fault), .aux_done_ack(ack),
    .emergency_out(emergency_out), .cycle_indicator(cycle_indicator), .bcd_code_lines(bcd),
    .strobes(strobes), .decoded_pins(decoded_pins), .feedback_alarm(feedback_alarm)
  );

  cabinet_model cabinet
  (
    .core_clk(core_clk), .reset(reset), .edge_mode(edge_mode), .low_delay(low_delay),
    .high_delay(high_delay), .bcd_code_lines(bcd), .strobes(strobes), .aux_done_ack(ack)
  );

  // ****************************************************************
  // Clock, checking and closing.
  // ****************************************************************
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    n_checks++;
    if (seen !== expected)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  function automatic logic [31:0] in_rng(input int v, input int lo, input int hi);
    return (v >= lo && v <= hi) ? 32'h0000_0001 : 32'h0000_0000;
  endfunction

  task automatic test_done();
    $display("Checks made %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge core_clk);
    n_fail++;
    test_done();
  end

  // ****************************************************************
  // Access tasks.
  // ****************************************************************
  task automatic settle();
    repeat (5) @(posedge core_clk);
  endtask

  task automatic wr(input logic [6:0] idx, input logic [15:0] set_m, input logic [15:0] clr_m);
    @(posedge core_clk);
    table_write <= 1'b1;
    table_index <= idx;
    table_entry <= '{valid: 1'b1, set_mask: set_m, clear_mask: clr_m};
    @(posedge core_clk);
    table_write <= 1'b0;
  endtask

  // Issues one request, tries a refused one meanwhile and logs when the code lines, strobes, acknowledge and done move.
  task automatic do_request(input aux_out_pkg::func_kind_t kind, input logic [7:0] code);
    {t_on, t_off, t_son, t_soff, t_al, t_ah, t_done} = {7{-32'sd1}};
    bcd_seen = 8'h00;
    stb_seen = 3'h0;
    @(posedge core_clk);
    request <= '{valid: 1'b1, kind: kind, code: code};
    for (int n = 0; n < 20000 && t_done < 0; n++)
    begin
      @(posedge core_clk);
      request <= (n == 5) ? aux_out_pkg::aux_request_t'{valid: 1'b1, kind: aux_out_pkg::FUNC_T, code: 8'h08} : '0;
      bcd_seen |= bcd;
      stb_seen |= strobes;
      if (bcd != 8'h00 && t_on < 0) t_on = n;
      if (t_on >= 0 && bcd == 8'h00 && t_off < 0) t_off = n;
      if (strobes != 3'h0 && t_son < 0) t_son = n;
      if (t_son >= 0 && strobes == 3'h0 && t_soff < 0) t_soff = n;
      if (ack === 1'b0 && t_al < 0) t_al = n;
      if (t_al >= 0 && ack === 1'b1 && t_ah < 0) t_ah = n;
      if (function_done === 1'b1) t_done = n;
    end
    settle();
    check(bcd, 8'h00);
    check(request_ready, 1'b1);
  endtask

  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial
  begin
    n_fail = 0;
    n_checks = 0;
    reset = 1'b1;
    cfg = '0;
    cancel = 5'h00;
    table_write = 1'b0;
    table_index = 7'h00;
    table_entry = '0;
    request = '0;
    {emergency, turret_positive, rapid_traverse, threading, block_exec, start_exec} = 6'h00;
    feedback_fault = 5'h00;
    edge_mode = 1'b0;
    low_delay = 10 * T;
    high_delay = 20 * T;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    check(request_ready, 1'b1);
    check({strobes, bcd, decoded_pins}, 27'h000_0000);
    for (int i = 0; i < 4; i++)
    begin
      cfg.emergency_polarity_sel <= i[1];
      emergency <= i[0];
      cfg.turret_dir_enable <= i[1];
      cfg.rapid_ind_enable <= i[1];
      turret_positive <= i[0];
      rapid_traverse <= i[0];
      settle();
      check(emergency_out, i[1] ^ i[0]);
      check(decoded_pins[13], i[1] & i[0]);
      check(decoded_pins[14], i[1] & i[0]);
    end
    for (int i = 0; i < 16; i++)
    begin
      {cfg.cycle_ind_select, threading, block_exec, start_exec} <= i[3:0];
      settle();
      check(cycle_indicator, i[3] ? (i[1] | i[0]) : i[2]);
    end
    feedback_fault <= 5'h1f;
    for (int i = 0; i < 5; i++)
    begin
      cancel <= 5'h01 << i;
      settle();
      check(feedback_alarm, 5'(~(5'h01 << i)));
    end
    feedback_fault <= 5'h00;
    settle();
    check(feedback_alarm, 5'h00);
    cfg <= '{bcd_suppress: 1'b1, default: 1'b0};
    {turret_positive, rapid_traverse} <= 2'h0;
    wr(7'h14, 16'h2020, 16'h0000);
    wr(7'h63, 16'h0001, 16'h0000);
    wr(7'h07, 16'h0080, 16'h2000);
    do_request(aux_out_pkg::FUNC_M, 8'h14);
    check(in_rng(t_done, 0, 3), 1);
    check(decoded_pins, 16'h2020);
    do_request(aux_out_pkg::FUNC_M, 8'h63);
    check({bcd_seen, decoded_pins}, 24'h00_2021);
    cfg.bcd_suppress <= 1'b0;
    do_request(aux_out_pkg::FUNC_M, 8'h07);
    check({bcd_seen, stb_seen}, 11'h038);
    check(decoded_pins, 16'h00a1);
    check(in_rng(t_off - t_on, 199 * T - 2, 200 * T + 2), 1);
    check(in_rng(t_done - t_ah, 1, 6), 1);
    cfg.falling_edge_wait <= 1'b1;
    edge_mode <= 1'b1;
    low_delay <= 120 * T;
    high_delay <= 80 * T;
    for (int k = 0; k < 3; k++)
    begin
      do_request(aux_out_pkg::func_kind_t'(k[1:0]), 8'h05 - k[7:0]);
      check({bcd_seen, stb_seen}, {8'h05 - k[7:0], 3'b100 >> k});
      check(in_rng(t_son - t_on, 49 * T - 2, 50 * T + 2), 1);
      check(in_rng(t_soff - t_al, 1, 20000), 1);
      check(in_rng(t_soff - t_al, 99 * T, 100 * T + 6), 1);
      check(in_rng(t_off - t_soff, 49 * T - 2, 50 * T + 2), 1);
      check(in_rng(t_done - t_ah, 1, 6), 1);
    end
    test_done();
  end
endmodule

// >>> aux_out_pkg.sv
// Package with constants and carrier types for the auxiliary function output block.
package aux_out_pkg;

  // ****************************************************************
  // Timing constants.
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned TICK_US         = 1000;
  localparam int unsigned TICK_CYCLES     = (CLK_HZ / 1000000) * TICK_US;
  localparam int unsigned CODE_ONLY_MS    = 200;
  localparam int unsigned CODE_TO_STB_MS  = 50;
  localparam int unsigned STB_HOLD_MS     = 100;
  localparam int unsigned CODE_HOLD_MS    = 50;
  localparam int unsigned MS_CNT_W        = 8;
  localparam int unsigned TICK_CNT_W      = 15;

  // ****************************************************************
  // Widths and decode table layout.
  // ****************************************************************
  localparam int unsigned BCD_W           = 8;
  localparam int unsigned DEC_W           = 16;
  localparam int unsigned TABLE_DEPTH     = 100;
  localparam int unsigned FB_CONN         = 5;
  localparam int unsigned DEC_IDX_13      = 13;
  localparam int unsigned DEC_IDX_14      = 14;

  // ****************************************************************
  // Carrier types.
  // ****************************************************************
  typedef enum logic [1:0]
  {
    FUNC_M = 2'b00,
    FUNC_S = 2'b01,
    FUNC_T = 2'b10
  } func_kind_t;

  typedef struct packed
  {
    logic       valid;
    func_kind_t kind;
    logic [7:0] code;
  } aux_request_t;

  typedef struct packed
  {
    logic             valid;
    logic [DEC_W-1:0] set_mask;
    logic [DEC_W-1:0] clear_mask;
  } decode_entry_t;

  typedef struct packed
  {
    logic emergency_polarity_sel;
    logic turret_dir_enable;
    logic rapid_ind_enable;
    logic cycle_ind_select;
    logic bcd_suppress;
    logic falling_edge_wait;
  } io_config_t;

  typedef struct packed
  {
    logic m;
    logic s;
    logic t;
  } strobe_t;

endpackage

// >>> cabinet_model.sv
// Behavioural model of the cabinet logic that acknowledges auxiliary functions.
`timescale 1ns/1ns

module cabinet_model
(
  // Clock and reset.
  input  wire logic                          core_clk,
  input  wire logic                          reset,
  // Behaviour control.
  input  wire logic                          edge_mode,
  input  wire logic [31:0]                   low_delay,
  input  wire logic [31:0]                   high_delay,
  // Device outputs.
  input  wire logic [aux_out_pkg::BCD_W-1:0] bcd_code_lines,
  input  wire aux_out_pkg::strobe_t          strobes,
  // Acknowledge back to the device.
  output logic                               aux_done_ack
);
  logic        busy;
  logic        busy_d;
  logic [31:0] cnt;

  // Work is the strobe in edge mode and the code on the lines otherwise.
  assign busy = edge_mode ? (strobes != 3'h0) : (bcd_code_lines != 8'h00);

  // The acknowledge rests high, falls after low_delay and rises after high_delay once work ends.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      busy_d       <= 1'b0;
      cnt          <= 32'h0000_0000;
      aux_done_ack <= 1'b1;
    end
    else
    begin
      busy_d <= busy;
      cnt    <= (busy != busy_d) ? 32'h0000_0000 : cnt + 32'h0000_0001;
      if (busy && (busy == busy_d) && (cnt == low_delay))
        aux_done_ack <= 1'b0;
      if (!busy && (busy == busy_d) && (cnt == high_delay))
        aux_done_ack <= 1'b1;
    end
  end
endmodule
